// file: pkg/ccp_pkg.sv
`default_nettype none
package ccp_pkg;
  // Clock rate, crystal activity watchdog and address strap settling
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned XTAL_QUIET_NS    = 1000;
  localparam int unsigned XTAL_QUIET_CYC   = (XTAL_QUIET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned QUIET_W          = 9;
  localparam logic [1:0]  STRAP_SETTLE_CYC = 2'h2;

  // Local offsets within a page
  localparam logic [7:0] OFS_DIE_REVISION  = 8'h00;
  localparam logic [7:0] OFS_PAGE_SELECT   = 8'h01;
  localparam logic [7:0] OFS_PART_LOW      = 8'h02;
  localparam logic [7:0] OFS_PART_HIGH     = 8'h03;
  localparam logic [7:0] OFS_SPEED_GRADE   = 8'h04;
  localparam logic [7:0] OFS_SILICON_REV   = 8'h05;
  localparam logic [7:0] OFS_TEMP_RANGE    = 8'h09;
  localparam logic [7:0] OFS_PACKAGE       = 8'h0a;
  localparam logic [7:0] OFS_BUS_ADDRESS   = 8'h0b;
  localparam logic [7:0] OFS_DEV_LIVE      = 8'h0c;
  localparam logic [7:0] OFS_INPUT_LIVE    = 8'h0d;
  localparam logic [7:0] OFS_LOOP_LIVE     = 8'h0e;
  localparam logic [7:0] OFS_LOOP_CAL      = 8'h0f;
  localparam logic [7:0] OFS_DEV_STICKY    = 8'h11;
  localparam logic [7:0] OFS_INPUT_STICKY  = 8'h12;

  // Reset values and field layout
  localparam logic [7:0] PAGE_RESET        = 8'h00;
  localparam logic [7:0] PAGE_ZERO         = 8'h00;
  localparam logic [7:0] STICKY_RESET      = 8'h00;
  localparam logic [7:0] DEV_BITS_MASK     = 8'h2f;
  localparam int unsigned BIT_CALIBRATING  = 0;
  localparam int unsigned BIT_XTAL_ABSENT  = 1;
  localparam int unsigned BIT_REF_UNDET    = 2;
  localparam int unsigned BIT_REF_LOCKFAIL = 3;
  localparam int unsigned BIT_BUS_TIMEOUT  = 5;
  localparam int unsigned N_INPUTS         = 4;
  localparam int unsigned N_LOOPS          = 4;

  // Conditions from the monitors outside this bank
  typedef struct packed {
    logic [3:0] input_off_frequency;
    logic [3:0] input_no_signal;
    logic [3:0] loop_holdover;
    logic [3:0] loop_unlocked;
    logic [3:0] loop_calibrating;
    logic       device_calibrating;
    logic       reference_undetected;
    logic       reference_lock_failure;
    logic       bus_timeout;
  } ccp_monitor_t;

  // One register access from the serial engine
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccp_reg_req_t;
endpackage
`default_nettype wire

// file: rtl/ccp_page0_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ccp_page0_regs #(
  parameter logic [3:0]  DIE_REVISION   = 4'h2,    // Arbitrary value
  parameter logic [15:0] BASE_PART_CODE = 16'h1234, // Arbitrary value
  parameter logic [7:0]  SPEED_GRADE    = 8'h01,   // Arbitrary value
  parameter logic [7:0]  SILICON_REV    = 8'h02,   // Arbitrary value
  parameter logic [7:0]  TEMP_RANGE     = 8'h00,
  parameter logic [7:0]  PACKAGE_CODE   = 8'h00,
  parameter logic [4:0]  BUS_ADDR_HIGH  = 5'h1a    // Arbitrary value
) (
  input  wire logic                  clk_sys_i,               // System clock, 200 MHz
  input  wire logic                  sys_rst_i,               // Async reset, active high
  input  wire logic                  ce_i,                    // Clock enable, freezes state when low
  input  wire ccp_pkg::ccp_reg_req_t req_i,                   // Register access request
  output logic [7:0]                 rd_data_o,               // Read data, registered
  output logic                       ack_o,                   // Access done, one-cycle pulse
  output logic [7:0]                 page_o,                  // Currently selected page
  input  wire ccp_pkg::ccp_monitor_t mon_i,                   // Live conditions from monitors
  input  wire logic                  crystal_reference_input, // Crystal clock, asynchronous
  input  wire logic                  address_select_high_pin, // Address strap, asynchronous
  input  wire logic                  address_select_low_pin,  // Address strap, asynchronous
  output logic [7:0]                 dev_live_o,              // Device live status
  output logic [7:0]                 dev_sticky_o,            // Device sticky flags
  output logic [7:0]                 input_sticky_o           // Input sticky flags
);
  import ccp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers

  logic [1:0]         xtal_sync;
  logic               xtal_prev;
  logic [1:0]         a_hi_sync;
  logic [1:0]         a_lo_sync;
  logic               strap_taken;
  logic [1:0]         strap_wait;
  logic [1:0]         addr_strap;
  logic [QUIET_W-1:0] quiet_cnt;
  logic               crystal_signal_absent;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      xtal_sync <= 2'h0;
      xtal_prev <= 1'b0;
      a_hi_sync <= 2'h0;
      a_lo_sync <= 2'h0;
    end else if (ce_i) begin
      xtal_sync <= {xtal_sync[0], crystal_reference_input};
      xtal_prev <= xtal_sync[1];
      a_hi_sync <= {a_hi_sync[0], address_select_high_pin};
      a_lo_sync <= {a_lo_sync[0], address_select_low_pin};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crystal activity watchdog

  wire xtal_edge = xtal_sync[1] ^ xtal_prev;
  wire quiet_full = (quiet_cnt == QUIET_W'(XTAL_QUIET_CYC));

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      quiet_cnt <= '0;
    end else if (ce_i) begin
      if (xtal_edge) begin
        quiet_cnt <= '0;
      end else if (!quiet_full) begin
        quiet_cnt <= quiet_cnt + QUIET_W'(1);
      end
    end
  end

  assign crystal_signal_absent = quiet_full;

  ////////////////////////////////////////////////////////////////////////////
  // Address strap, caught once after reset release

  // Wait until the pin synchronisers have filled before sampling
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_wait  <= 2'h0;
      strap_taken <= 1'b0;
      addr_strap  <= 2'h0;
    end else if (ce_i && !strap_taken) begin
      if (strap_wait == STRAP_SETTLE_CYC) begin
        strap_taken <= 1'b1;
        addr_strap  <= {a_hi_sync[1], a_lo_sync[1]};
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  // Only the strap and a constant feed it; no save path exists
  wire [7:0] bus_address = {1'b0, BUS_ADDR_HIGH, addr_strap};

  ////////////////////////////////////////////////////////////////////////////
  // Live status

  logic [7:0] input_live;
  logic [7:0] loop_live;
  logic [7:0] loop_cal;

  always_comb begin
    dev_live_o                   = 8'h00;
    dev_live_o[BIT_CALIBRATING]  = mon_i.device_calibrating;
    dev_live_o[BIT_XTAL_ABSENT]  = crystal_signal_absent;
    dev_live_o[BIT_REF_UNDET]    = mon_i.reference_undetected;
    dev_live_o[BIT_REF_LOCKFAIL] = mon_i.reference_lock_failure;
    dev_live_o[BIT_BUS_TIMEOUT]  = mon_i.bus_timeout;
    input_live = {mon_i.input_off_frequency, mon_i.input_no_signal};
    loop_live  = {mon_i.loop_holdover, mon_i.loop_unlocked};
    loop_cal   = {mon_i.loop_calibrating, 4'h0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  logic [7:0] page_select;
  wire        wr_hit    = ce_i && req_i.valid && req_i.write;
  wire        on_page0  = (page_select == PAGE_ZERO);
  wire        wr_page   = wr_hit && (req_i.addr == OFS_PAGE_SELECT);
  wire        wr_dsticky = wr_hit && on_page0 && (req_i.addr == OFS_DEV_STICKY);
  wire        wr_isticky = wr_hit && on_page0 && (req_i.addr == OFS_INPUT_STICKY);

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      page_select <= PAGE_RESET;
    end else if (wr_page) begin
      page_select <= req_i.wdata;
    end
  end

  assign page_o = page_select;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags, set wins over clear

  logic [7:0] dev_clear;
  logic [7:0] input_clear;

  always_comb begin
    dev_clear   = 8'h00;
    input_clear = 8'h00;
    if (wr_dsticky) begin
      dev_clear = ~req_i.wdata & ~dev_live_o & DEV_BITS_MASK;
    end
    if (wr_isticky) begin
      input_clear = ~req_i.wdata & ~input_live;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sticky
      always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          dev_sticky_o[gi]   <= STICKY_RESET[gi];
          input_sticky_o[gi] <= STICKY_RESET[gi];
        end else if (ce_i) begin
          dev_sticky_o[gi]   <= dev_live_o[gi] | (dev_sticky_o[gi] & ~dev_clear[gi]);
          input_sticky_o[gi] <= input_live[gi] | (input_sticky_o[gi] & ~input_clear[gi]);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = 8'h00;
    if (req_i.addr == OFS_PAGE_SELECT) begin
      next_rd_data = page_select;
    end else if (on_page0) begin
      unique case (req_i.addr)
        OFS_DIE_REVISION: next_rd_data = {4'h0, DIE_REVISION};
        OFS_PART_LOW:     next_rd_data = BASE_PART_CODE[7:0];
        OFS_PART_HIGH:    next_rd_data = BASE_PART_CODE[15:8];
        OFS_SPEED_GRADE:  next_rd_data = SPEED_GRADE;
        OFS_SILICON_REV:  next_rd_data = SILICON_REV;
        OFS_TEMP_RANGE:   next_rd_data = TEMP_RANGE;
        OFS_PACKAGE:      next_rd_data = PACKAGE_CODE;
        OFS_BUS_ADDRESS:  next_rd_data = bus_address;
        OFS_DEV_LIVE:     next_rd_data = dev_live_o;
        OFS_INPUT_LIVE:   next_rd_data = input_live;
        OFS_LOOP_LIVE:    next_rd_data = loop_live;
        OFS_LOOP_CAL:     next_rd_data = loop_cal;
        OFS_DEV_STICKY:   next_rd_data = dev_sticky_o;
        OFS_INPUT_STICKY: next_rd_data = input_sticky_o;
        default:          next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
      ack_o     <= 1'b0;
    end else if (ce_i) begin
      ack_o <= req_i.valid;
      if (req_i.valid && !req_i.write) begin
        rd_data_o <= next_rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  a_page_write_takes: assert property (wr_page |=> page_o == $past(req_i.wdata))
    else $error("page select did not take written value");
  a_page_reads_back: assert property (ce_i && req_i.valid && !req_i.write && req_i.addr == OFS_PAGE_SELECT
    |=> rd_data_o == $past(page_o) && ack_o)
    else $error("page read does not match page");
  a_page_holds: assert property (!wr_page |=> page_o == $past(page_o))
    else $error("page changed without write");
  a_dev_sticky_set: assert property (ce_i && dev_live_o[BIT_BUS_TIMEOUT] |=> dev_sticky_o[BIT_BUS_TIMEOUT])
    else $error("device sticky flag not set");
  a_input_sticky_set: assert property (ce_i && input_live[0] |=> input_sticky_o[0])
    else $error("input sticky flag not set");
  a_clear_blocked: assert property (wr_isticky && input_live[4] && !req_i.wdata[4] |=> input_sticky_o[4])
    else $error("sticky cleared while live");
  a_clear_on_zero: assert property (wr_dsticky && !req_i.wdata[2] && !dev_live_o[2] |=> !dev_sticky_o[2])
    else $error("sticky not cleared by zero write");
  a_write_one_keeps: assert property (wr_isticky && req_i.wdata[1] && input_sticky_o[1] |=> input_sticky_o[1])
    else $error("writing one disturbed a flag");
  a_reserved_zero: assert property (!dev_live_o[4] && !dev_sticky_o[4] && !dev_sticky_o[6] && !dev_sticky_o[7])
    else $error("undefined device bit set");
  a_strap_stable: assert property (strap_taken |=> $stable(addr_strap))
    else $error("address strap changed after capture");
  a_xtal_quiet: assert property (ce_i && xtal_edge |=> !crystal_signal_absent)
    else $error("crystal absent despite edge");

  wire rd_take = ce_i && req_i.valid && !req_i.write;

  a_write_acked: assert property (
    ce_i && req_i.valid && req_i.write
    |=> ack_o)
    else $error("write not acknowledged");
  a_read_acked: assert property (
    rd_take
    |=> ack_o)
    else $error("read not acknowledged");
  a_ack_idle: assert property (
    ce_i && !req_i.valid
    |=> !ack_o)
    else $error("acknowledge without request");
  a_freeze_page: assert property (
    !ce_i
    |=> $stable(page_o))
    else $error("page changed while disabled");
  a_freeze_sticky: assert property (
    !ce_i
    |=> $stable(dev_sticky_o) && $stable(input_sticky_o))
    else $error("sticky flags changed while disabled");
  a_read_data_holds: assert property (
    !rd_take
    |=> $stable(rd_data_o))
    else $error("read data changed without read");
  a_offpage_zero: assert property (
    rd_take && !on_page0 && req_i.addr != OFS_PAGE_SELECT
    |=> rd_data_o == 8'h00)
    else $error("off-page read not zero");
  a_die_rev_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_DIE_REVISION
    |=> rd_data_o == {4'h0, DIE_REVISION})
    else $error("die revision read wrong");
  a_part_low_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_PART_LOW
    |=> rd_data_o == BASE_PART_CODE[7:0])
    else $error("part code low byte wrong");
  a_part_high_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_PART_HIGH
    |=> rd_data_o == BASE_PART_CODE[15:8])
    else $error("part code high byte wrong");
  a_speed_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_SPEED_GRADE
    |=> rd_data_o == SPEED_GRADE)
    else $error("speed grade read wrong");
  a_silicon_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_SILICON_REV
    |=> rd_data_o == SILICON_REV)
    else $error("revision code read wrong");
  a_temp_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_TEMP_RANGE
    |=> rd_data_o == TEMP_RANGE)
    else $error("temperature code read wrong");
  a_package_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_PACKAGE
    |=> rd_data_o == PACKAGE_CODE)
    else $error("package code read wrong");
  a_address_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_BUS_ADDRESS
    |=> rd_data_o == {1'b0, BUS_ADDR_HIGH, $past(addr_strap)})
    else $error("bus address read wrong");
  a_address_no_write: assert property (
    wr_hit && req_i.addr == OFS_BUS_ADDRESS
    |=> $stable(addr_strap))
    else $error("bus address changed by write");
  a_calib_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_DEV_LIVE
    |=> rd_data_o[BIT_CALIBRATING] == $past(mon_i.device_calibrating))
    else $error("calibration bit read wrong");
  a_reference_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_DEV_LIVE
    |=> rd_data_o[3:2] == $past({mon_i.reference_lock_failure, mon_i.reference_undetected}))
    else $error("reference fault bits read wrong");
  a_timeout_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_DEV_LIVE
    |=> rd_data_o[BIT_BUS_TIMEOUT] == $past(mon_i.bus_timeout))
    else $error("bus timeout bit read wrong");
  a_input_live_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_INPUT_LIVE
    |=> rd_data_o == $past({mon_i.input_off_frequency, mon_i.input_no_signal}))
    else $error("input status read wrong");
  a_loop_live_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_LOOP_LIVE
    |=> rd_data_o == $past({mon_i.loop_holdover, mon_i.loop_unlocked}))
    else $error("loop status read wrong");
  a_loop_cal_read: assert property (
    rd_take && on_page0 && req_i.addr == OFS_LOOP_CAL
    |=> rd_data_o == {$past(mon_i.loop_calibrating), 4'h0})
    else $error("loop calibration read wrong");
  a_xtal_absent_set: assert property (
    ce_i && !xtal_edge && quiet_cnt == QUIET_W'(XTAL_QUIET_CYC - 1)
    |=> crystal_signal_absent)
    else $error("crystal absence not reported");

  genvar gk;
  generate
    for (gk = 0; gk < 8; gk++) begin : g_sticky_check
      a_dsticky_hold: assert property (
        ce_i && dev_sticky_o[gk] && !wr_dsticky
        |=> dev_sticky_o[gk])
        else $error("device sticky flag dropped");
      a_isticky_hold: assert property (
        ce_i && input_sticky_o[gk] && !wr_isticky
        |=> input_sticky_o[gk])
        else $error("input sticky flag dropped");
      a_isticky_clear: assert property (
        wr_isticky && !req_i.wdata[gk] && !input_live[gk]
        |=> !input_sticky_o[gk])
        else $error("input sticky not cleared by zero write");
      a_isticky_block: assert property (
        wr_isticky && input_live[gk]
        |=> input_sticky_o[gk])
        else $error("input sticky cleared while live");
      a_dsticky_keep: assert property (
        wr_dsticky && req_i.wdata[gk] && dev_sticky_o[gk]
        |=> dev_sticky_o[gk])
        else $error("writing one cleared a device flag");
    end
  endgenerate
endmodule
`default_nettype wire

// file: tb/ccp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccp_host_model (
  input  wire logic              clk_i, // System clock
  input  wire logic              ack_i, // Access done pulse
  input  wire logic [7:0]        rd_i,  // Read data
  output var ccp_pkg::ccp_reg_req_t req_o // Request to bank
);
  import ccp_pkg::*;
  initial req_o = '{1'b0, 1'b0, 8'h00, 8'h00};
  // One access held for one taking edge; released fields show the inverse
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic ok, output logic [7:0] q);
    @(negedge clk_i);
    req_o = '{1'b1, w, a, d};
    @(negedge clk_i);
    ok = ack_i;
    q = rd_i;
    req_o = '{1'b0, ~w, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// file: tb/test_ccp_page0_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_ccp_page0_regs;
  import ccp_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         xtal = 1'b0;
  logic         xtal_run = 1'b1;
  logic         ce = 1'b1;
  logic         pin_hi = 1'b1;
  logic         pin_lo = 1'b0;
  ccp_reg_req_t req;
  ccp_monitor_t mon = '0;
  logic [7:0]   rdata, page, dlive, dsticky, isticky;
  logic         ack;
  int           errors = 0;
  int           checks = 0;
  int           cycles = 0;
  always #2.5 clk = ~clk;
  always #80 if (xtal_run) xtal = ~xtal;
  ccp_page0_regs ccp_page0_regs_inst (
    .clk_sys_i(clk), .sys_rst_i(rst), .ce_i(ce), .req_i(req), .rd_data_o(rdata),
    .ack_o(ack), .page_o(page), .mon_i(mon), .crystal_reference_input(xtal),
    .address_select_high_pin(pin_hi), .address_select_low_pin(pin_lo), .dev_live_o(dlive),
    .dev_sticky_o(dsticky), .input_sticky_o(isticky));
  ccp_host_model ccp_host_model_inst (.clk_i(clk), .ack_i(ack), .rd_i(rdata), .req_o(req));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic ok;
    logic [7:0] q;
    ccp_host_model_inst.acc(1'b0, a, 8'h00, ok, q);
    chk("ack_o", 8'h01, {7'h00, ok});
    chk($sformatf("read %h", a), e, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    logic [7:0] q;
    ccp_host_model_inst.acc(1'b1, a, d, ok, q);
    chk("ack_o", 8'h01, {7'h00, ok});
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_ids;
    logic ok;
    logic [7:0] q;
    logic [7:0] ofs [9] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h09, 8'h0a, 8'h0b, 8'h07, 8'h10};
    logic [7:0] exp [9] = '{8'h34, 8'h12, 8'h01, 8'h02, 8'h00, 8'h00, {1'b0, 5'h1a, 2'b10}, 8'h00, 8'h00};
    ccp_host_model_inst.acc(1'b0, 8'h00, 8'h00, ok, q);
    chk("die_revision", 8'h02, {4'h0, q[3:0]});
    for (int i = 0; i < 9; i++) begin
      rd(ofs[i], exp[i]);
    end
    wr(8'h02, 8'hff);
    wr(8'h0b, 8'h00);
    rd(8'h02, 8'h34);
    rd(8'h0b, 8'h6a);
  endtask
  task automatic test_page;
    rd(8'h01, 8'h00);
    wr(8'h01, 8'hff);
    chk("page_o", 8'hff, page);
    rd(8'h01, 8'hff);
    rd(8'h02, 8'h00);
    wr(8'h01, 8'h00);
    rd(8'h02, 8'h34);
  endtask
  task automatic test_enable;
    logic ok;
    logic [7:0] q;
    @(negedge clk);
    ce = 1'b0;
    ccp_host_model_inst.acc(1'b1, 8'h01, 8'h33, ok, q);
    ce = 1'b1;
    chk("ack_o", 8'h00, {7'h00, ok});
    chk("page_o", 8'h00, page);
  endtask
  task automatic test_reset;
    wr(8'h01, 8'h05);
    @(negedge clk);
    mon.input_no_signal = 4'h8;
    @(negedge clk);
    mon = '0;
    pin_hi = 1'b0;
    pin_lo = 1'b1;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("page_o", 8'h00, page);
    chk("input_sticky_o", 8'h00, isticky);
    repeat (4) @(negedge clk);
    rd(8'h0b, 8'h69);
  endtask
  task automatic test_status;
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    @(negedge clk);
    mon = '{4'ha, 4'h5, 4'h3, 4'hc, 4'h9, 1'b1, 1'b0, 1'b1, 1'b1};
    rd(8'h0c, 8'h29);
    chk("dev_live_o", 8'h29, dlive);
    rd(8'h0d, 8'ha5);
    rd(8'h0e, 8'h3c);
    rd(8'h0f, 8'h90);
    @(negedge clk);
    mon = '{4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1};
    rd(8'h0c, 8'h20);
    rd(8'h11, 8'h29);
    rd(8'h12, 8'ha5);
    wr(8'h11, 8'hff);
    wr(8'h12, 8'hff);
    chk("dev_sticky_o", 8'h29, dsticky);
    chk("input_sticky_o", 8'ha5, isticky);
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h00);
    rd(8'h11, 8'h20);
    rd(8'h12, 8'h01);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h20);
    @(negedge clk);
    mon = '0;
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
  endtask
  task automatic test_crystal;
    xtal_run = 1'b0;
    repeat (250) @(negedge clk);
    chk("dev_live_o", 8'h02, dlive);
    rd(8'h11, 8'h02);
    xtal_run = 1'b1;
    repeat (60) @(negedge clk);
    chk("dev_live_o", 8'h00, dlive);
    wr(8'h11, 8'h00);
    rd(8'h11, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    test_ids();
    test_page();
    test_enable();
    test_status();
    test_crystal();
    test_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
